//--- rtl/ptsp_status_port.v
// processor trace status port: status code, captured-data nibble and status clock
//
// Summary of operation
// - codes 0000 continue, 0001 begin, 0011 user
// - 0100 marker/debug write, 0111 exception return
// - 0101 on taken branch or pc sync
// - 1000..1011 announce one..four byte nibble transfer
// - 1100 exception, 1101 emulator entry exception
// - 1110 stopped awaiting interrupt, 1111 halted
// - exception, emulator, stop, halt held multiple cycles
// - four-bit bus shows captured data, breakpoint status
// - codes change with status clock, follow execution
// - status clock times nibble and code outputs
// - status clock at half the core (sys_clk) rate
// - force-high-impedance low floats outputs, clock independent
// - boundary scan overrides force-high-impedance
`timescale 1ns/100ps
`default_nettype none
`include "ptsp_map.vh"

module ptsp_status_port #(
   parameter                          HOLD_CYCLES = `PTSP_HOLD_DEFAULT
) (
   input  wire                        sys_clk_i,
   input  wire                        rst_i,
   input  wire                        instr_begin_i,
   input  wire                        user_entry_i,
   input  wire                        debug_data_write_instruction_i,
   input  wire                        exception_return_instruction_i,
   input  wire                        taken_branch_i,
   input  wire                        program_counter_sync_i,
   input  wire                        exception_i,
   input  wire                        emulator_entry_i,
   input  wire                        stopped_i,
   input  wire                        halted_i,
   input  wire                        capture_valid_i,
   input  wire [`PTSP_CAPT_W-1:0]     capture_data_i,
   input  wire [1:0]                  capture_bytes_i,
   output wire                        capture_ready_o,
   input  wire [`PTSP_NIBBLE_W-1:0]   breakpoint_status_i,
   input  wire [`PTSP_TEST_W-1:0]     test_mode_i,
   input  wire                        force_high_impedance_n_i,
   input  wire                        scan_active_i,
   input  wire                        scan_output_enable_i,
   output reg  [`PTSP_CODE_W-1:0]     processor_status_code_o,
   output wire                        processor_status_code_oe_o,
   output reg  [`PTSP_NIBBLE_W-1:0]   captured_data_nibble_o,
   output wire                        captured_data_nibble_oe_o,
   output reg                         status_clock_out_o,
   output wire                        status_clock_out_oe_o,
   output reg                         debug_vs_scan_select_o
);

   // -------------------------------------------------------------------------
   // status clock
   // -------------------------------------------------------------------------
   // the status clock is sys_clk divided by two; codes and nibbles change with
   // its rising edge, so a probe samples them on its falling edge
   wire                               core_tick;
   assign core_tick = ~status_clock_out_o;

   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         status_clock_out_o <= 1'b0;
      end else begin
         status_clock_out_o <= ~status_clock_out_o;
      end
   end

   // -------------------------------------------------------------------------
   // test-mode select
   // -------------------------------------------------------------------------
   // sampled every cycle out of reset; the probe keeps it steady while reset
   // is high, and the select then follows every later change of it
   // limitation: only the select is made here; serial and scan pins live elsewhere
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         debug_vs_scan_select_o <= 1'b0;
      end else begin
         debug_vs_scan_select_o <= (test_mode_i == `PTSP_TEST_BDM);
      end
   end

   // -------------------------------------------------------------------------
   // output drivers
   // -------------------------------------------------------------------------
   // purely combinational so the float takes effect with no clock edge
   // only the enables are made here; the pad cells sit outside this block
   wire                               drive_en;
   assign drive_en = scan_active_i ? scan_output_enable_i
                                   : force_high_impedance_n_i;
   assign processor_status_code_oe_o = drive_en;
   assign captured_data_nibble_oe_o  = drive_en;
   assign status_clock_out_oe_o      = drive_en;

   // -------------------------------------------------------------------------
   // nibble transfer engine
   // -------------------------------------------------------------------------
   reg  [`PTSP_CAPT_W-1:0]            capt_shift;
   reg  [`PTSP_CNT_W-1:0]             nib_left;
   reg  [`PTSP_CNT_W-1:0]             next_nib_left;
   reg  [`PTSP_CAPT_W-1:0]            next_capt_shift;
   reg  [`PTSP_NIBBLE_W-1:0]          next_nibble;
   wire                               xfer_busy;
   wire                               xfer_start;
   wire                               long_busy;
   wire                               long_event;

   assign xfer_busy = (nib_left != `PTSP_ZERO_CNT);
   // the long-held codes outrank a transfer announce; a capture taken on the
   // same edge would send its nibbles with no announce code ahead of them
   assign long_event = halted_i | stopped_i | emulator_entry_i | exception_i;
   // a new capture is taken only on a status clock edge with the bus free and
   // no long-held code running or starting, so the announce is never swallowed
   assign capture_ready_o = core_tick & ~xfer_busy & ~long_busy & ~long_event;
   assign xfer_start      = capture_valid_i & capture_ready_o;

   // number of nibbles for a byte count, count given as bytes minus one;
   // four bytes need eight nibbles, so the counter must be able to hold eight
   function [`PTSP_CNT_W-1:0] nibbles_for;
      input [1:0] bytes_m1;
      begin
         nibbles_for = {1'b0, bytes_m1, 1'b0} + `PTSP_TWO_CNT;
      end
   endfunction

   always @* begin
      next_nib_left   = nib_left;
      next_capt_shift = capt_shift;
      next_nibble     = captured_data_nibble_o;
      if (core_tick) begin
         if (xfer_busy) begin
            // low nibble first, one nibble per status clock
            next_nibble     = capt_shift[`PTSP_NIBBLE_W-1:0];
            next_capt_shift = capt_shift >> `PTSP_NIBBLE_W;
            next_nib_left   = nib_left - `PTSP_ONE_CNT;
         end else begin
            // between transfers the bus shows breakpoint status, never stale data
            next_nibble = breakpoint_status_i;
         end
         if (xfer_start) begin
            next_capt_shift = capture_data_i;
            next_nib_left   = nibbles_for(capture_bytes_i);
         end
      end
   end

   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         nib_left               <= `PTSP_ZERO_CNT;
         capt_shift             <= {`PTSP_CAPT_W{1'b0}};
         captured_data_nibble_o <= {`PTSP_NIBBLE_W{1'b0}};
      end else begin
         nib_left               <= next_nib_left;
         capt_shift             <= next_capt_shift;
         captured_data_nibble_o <= next_nibble;
      end
   end

   // -------------------------------------------------------------------------
   // status code selection
   // -------------------------------------------------------------------------
   localparam                         ST_RUN  = 2'b00;
   localparam                         ST_HOLD = 2'b01;
   localparam                         ST_LEVEL = 2'b10;
   // the edge that enters a held code counts as its first status clock
   localparam [`PTSP_HOLD_W-1:0]      HOLD_LOAD =
                                      HOLD_CYCLES[`PTSP_HOLD_W-1:0] - `PTSP_ONE_HOLD;

   reg  [1:0]                         state;
   reg  [1:0]                         next_state;
   reg  [`PTSP_HOLD_W-1:0]            hold_cnt;
   reg  [`PTSP_HOLD_W-1:0]            next_hold_cnt;
   reg  [`PTSP_CODE_W-1:0]            next_code;

   assign long_busy = (state != ST_RUN);

   // one-cycle codes, highest priority first; reserved codes never chosen
   function [`PTSP_CODE_W-1:0] short_code;
      input       x_start;
      input [1:0] x_bytes;
      input       ret;
      input       marker;
      input       branch;
      input       user;
      input       begin_i;
      begin
         if (x_start) begin
            short_code = `PTSP_CODE_XFER_BASE | {2'b00, x_bytes};
         end else if (ret) begin
            short_code = `PTSP_CODE_EXC_RETURN;
         end else if (marker) begin
            short_code = `PTSP_CODE_MARKER;
         end else if (branch) begin
            short_code = `PTSP_CODE_BRANCH;
         end else if (user) begin
            short_code = `PTSP_CODE_USER;
         end else if (begin_i) begin
            short_code = `PTSP_CODE_BEGIN;
         end else begin
            short_code = `PTSP_CODE_CONTINUE;
         end
      end
   endfunction

   always @* begin
      next_state    = state;
      next_hold_cnt = hold_cnt;
      next_code     = processor_status_code_o;
      if (core_tick) begin
         case (state)
            ST_RUN: begin
               if (halted_i) begin
                  next_code  = `PTSP_CODE_HALTED;
                  next_state = ST_LEVEL;
                  next_hold_cnt = HOLD_LOAD;
               end else if (stopped_i) begin
                  next_code  = `PTSP_CODE_STOPPED;
                  next_state = ST_LEVEL;
                  next_hold_cnt = HOLD_LOAD;
               end else if (emulator_entry_i) begin
                  next_code  = `PTSP_CODE_EMU_ENTRY;
                  next_state = ST_HOLD;
                  next_hold_cnt = HOLD_LOAD;
               end else if (exception_i) begin
                  next_code  = `PTSP_CODE_EXCEPTION;
                  next_state = ST_HOLD;
                  next_hold_cnt = HOLD_LOAD;
               end else begin
                  next_code = short_code(xfer_start, capture_bytes_i,
                                         exception_return_instruction_i,
                                         debug_data_write_instruction_i,
                                         taken_branch_i | program_counter_sync_i,
                                         user_entry_i, instr_begin_i);
               end
            end
            ST_HOLD: begin
               // exception codes stand for a fixed number of status clocks
               // the return tick shows continue and drops any events, so the
               // end of a held code is always visible to the probe
               if (hold_cnt == {`PTSP_HOLD_W{1'b0}}) begin
                  next_state = ST_RUN;
                  next_code  = `PTSP_CODE_CONTINUE;
               end else begin
                  next_hold_cnt = hold_cnt - `PTSP_ONE_HOLD;
               end
            end
            ST_LEVEL: begin
               // stop and halt stand at least the minimum, then while asserted
               // halt outranks stop once the minimum has run, as at entry
               if (hold_cnt != {`PTSP_HOLD_W{1'b0}}) begin
                  next_hold_cnt = hold_cnt - `PTSP_ONE_HOLD;
               end else if (halted_i) begin
                  next_code = `PTSP_CODE_HALTED;
               end else if (stopped_i) begin
                  next_code = `PTSP_CODE_STOPPED;
               end else begin
                  next_state = ST_RUN;
                  next_code  = `PTSP_CODE_CONTINUE;
               end
            end
            default: begin
               next_state = ST_RUN;
               next_code  = `PTSP_CODE_CONTINUE;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // reserved code guard
   // -------------------------------------------------------------------------
   // no path above selects a reserved code; this catches one that a corrupted
   // code register might still hold, since a probe would read it
   // as garbage and lose its place in the trace
   function is_reserved;
      input [`PTSP_CODE_W-1:0] code;
      begin
         is_reserved = (code == `PTSP_CODE_RSVD_A) | (code == `PTSP_CODE_RSVD_B);
      end
   endfunction

   reg  [`PTSP_CODE_W-1:0]            next_safe_code;

   always @* begin
      next_safe_code = next_code;
      if (is_reserved(next_code)) begin
         next_safe_code = `PTSP_CODE_CONTINUE;
      end
   end

   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         state                   <= ST_RUN;
         hold_cnt                <= {`PTSP_HOLD_W{1'b0}};
         processor_status_code_o <= `PTSP_CODE_CONTINUE;
      end else begin
         state                   <= next_state;
         hold_cnt                <= next_hold_cnt;
         processor_status_code_o <= next_safe_code;
      end
   end

endmodule // ptsp_status_port

`default_nettype wire

//--- rtl/ptsp_map.vh
// constants for the processor trace status port
`ifndef PTSP_MAP_VH
`define PTSP_MAP_VH

// ----------------------------------------------------------------------------
// status code encodings
// ----------------------------------------------------------------------------
`define PTSP_CODE_CONTINUE   4'h0
`define PTSP_CODE_BEGIN      4'h1
`define PTSP_CODE_RSVD_A     4'h2
`define PTSP_CODE_USER       4'h3
`define PTSP_CODE_MARKER     4'h4
`define PTSP_CODE_BRANCH     4'h5
`define PTSP_CODE_RSVD_B     4'h6
`define PTSP_CODE_EXC_RETURN 4'h7
`define PTSP_CODE_XFER_BASE  4'h8
`define PTSP_CODE_EXCEPTION  4'hC
`define PTSP_CODE_EMU_ENTRY  4'hD
`define PTSP_CODE_STOPPED    4'hE
`define PTSP_CODE_HALTED     4'hF

// ----------------------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------------------
`define PTSP_CODE_W          4
`define PTSP_NIBBLE_W        4
`define PTSP_CAPT_W          32
`define PTSP_CNT_W           4
`define PTSP_HOLD_DEFAULT    2
`define PTSP_HOLD_W          4
`define PTSP_ONE_HOLD        4'h1
`define PTSP_ONE_CNT         4'h1
`define PTSP_ZERO_CNT        4'h0
`define PTSP_TWO_CNT         4'h2

// ----------------------------------------------------------------------------
// test-mode select codes
// ----------------------------------------------------------------------------
`define PTSP_TEST_W          4
`define PTSP_TEST_JTAG       4'h0
`define PTSP_TEST_BDM        4'h1

`endif

//--- bench/ptsp_status_port_asserts.sv
// concurrent checks on the trace status port pins
`timescale 1ns/100ps
`default_nettype none
module ptsp_status_port_chk #(
   parameter int HOLD_CYCLES = 2
) (
   input wire logic        sys_clk_i,
   input wire logic        rst_i,
   input wire logic        instr_begin_i,
   input wire logic        user_entry_i,
   input wire logic        debug_data_write_instruction_i,
   input wire logic        exception_return_instruction_i,
   input wire logic        taken_branch_i,
   input wire logic        program_counter_sync_i,
   input wire logic        exception_i,
   input wire logic        emulator_entry_i,
   input wire logic        stopped_i,
   input wire logic        halted_i,
   input wire logic        capture_valid_i,
   input wire logic [31:0] capture_data_i,
   input wire logic [1:0]  capture_bytes_i,
   input wire logic        capture_ready_o,
   input wire logic [3:0]  test_mode_i,
   input wire logic        force_high_impedance_n_i,
   input wire logic        scan_active_i,
   input wire logic        scan_output_enable_i,
   input wire logic [3:0]  processor_status_code_o,
   input wire logic        processor_status_code_oe_o,
   input wire logic [3:0]  captured_data_nibble_o,
   input wire logic        captured_data_nibble_oe_o,
   input wire logic        status_clock_out_o,
   input wire logic        status_clock_out_oe_o,
   input wire logic        debug_vs_scan_select_o
);
   localparam int HOLD_SYS = 2 * HOLD_CYCLES;
   logic [9:0] evs;
   logic [7:0] held_run;
   assign evs = {halted_i, stopped_i, emulator_entry_i, exception_i, program_counter_sync_i,
      taken_branch_i, exception_return_instruction_i, debug_data_write_instruction_i,
      user_entry_i, instr_begin_i};
   // saturates so a long stop never wraps into a false short run
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || processor_status_code_o < 4'hC)
         held_run <= 8'h00;
      else if (held_run != 8'hFF)
         held_run <= held_run + 8'h01;
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   a_oe_select: assert property ({processor_status_code_oe_o, captured_data_nibble_oe_o,
      status_clock_out_oe_o} == {3{scan_active_i ? scan_output_enable_i
      : force_high_impedance_n_i}}) else $error("output enable wrong");
   a_clk_toggle: assert property (!$past(rst_i) |->
      status_clock_out_o != $past(status_clock_out_o)) else $error("status clock stuck");
   a_no_reserved: assert property (processor_status_code_o != 4'h2
      && processor_status_code_o != 4'h6) else $error("reserved code driven");
   a_code_on_tick: assert property (!$past(rst_i) && $past(status_clock_out_o) |->
      $stable(processor_status_code_o) && $stable(captured_data_nibble_o))
      else $error("output moved off the status clock rise");
   a_branch_code: assert property (capture_ready_o && !capture_valid_i
      && (evs == 10'h010 || evs == 10'h020) |=> processor_status_code_o == 4'h5)
      else $error("branch code wrong");
   a_capture_code: assert property (capture_ready_o && capture_valid_i && evs[9:6] == 4'h0
      |=> processor_status_code_o == {2'b10, $past(capture_bytes_i)}) else $error("xfer code");
   a_first_nibble: assert property (capture_ready_o && capture_valid_i && evs[9:6] == 4'h0
      |-> ##3 captured_data_nibble_o == $past(capture_data_i[3:0], 3))
      else $error("first nibble wrong");
   a_exc_code: assert property (!status_clock_out_o && processor_status_code_o < 4'hC
      && evs[9:6] == 4'h1
      |=> (processor_status_code_o == 4'hC) [*2]) else $error("exception code wrong");
   a_hold_length: assert property (!$past(rst_i) && processor_status_code_o < 4'hC
      && $past(processor_status_code_o) >= 4'hC |-> $past(held_run) >= HOLD_SYS - 1)
      else $error("held code too short");
   a_halt_code: assert property (!status_clock_out_o && halted_i
      && processor_status_code_o < 4'hC
      |=> processor_status_code_o == 4'hF) else $error("halt code wrong");
   a_scan_select: assert property (1'b1 |=>
      debug_vs_scan_select_o == ($past(test_mode_i) == 4'h1)) else $error("select wrong");
   cover property (capture_ready_o && capture_valid_i);
   a_ready_blocked: assert property (capture_ready_o |-> evs[9:6] == 4'h0
      && !status_clock_out_o) else $error("capture accepted beside a held code");
   cover property (!status_clock_out_o && halted_i);
   cover property (processor_status_code_o == 4'hD);
endmodule // ptsp_status_port_chk
bind ptsp_status_port ptsp_status_port_chk #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (.*);
`default_nettype wire

//--- bench/ptsp_probe_model.sv
// trace probe model: samples the status pins and sets the test-mode code
`timescale 1ns/100ps
`default_nettype none
module ptsp_probe_model (
   input  wire logic       rst_i,
   input  wire logic       status_clock_out_i,
   input  wire logic [3:0] processor_status_code_i,
   input  wire logic [3:0] captured_data_nibble_i,
   output var  logic [3:0] test_mode_o
);
   logic [7:0] q[$];
   initial test_mode_o = 4'h0;
   // mid status period, so the launching edge never races the sample
   always @(negedge status_clock_out_i)
      q.push_back({processor_status_code_i, captured_data_nibble_i});
   task automatic set_mode(input logic [3:0] m);
      wait (rst_i === 1'b0);
      @(posedge status_clock_out_i);
      test_mode_o <= m;
   endtask
endmodule // ptsp_probe_model
`default_nettype wire

//--- bench/ptsp_status_port_test.sv
// self-checking bench for the processor trace status port
`timescale 1ns/100ps
`default_nettype none
module ptsp_status_port_test;
   logic sys_clk_i, rst_i, capture_valid_i, force_high_impedance_n_i;
   logic scan_active_i, scan_output_enable_i;
   logic [9:0] ev;
   logic [31:0] capture_data_i;
   logic [1:0] capture_bytes_i;
   logic [3:0] breakpoint_status_i;
   wire [3:0] test_mode_i, processor_status_code_o, captured_data_nibble_o;
   wire instr_begin_i, user_entry_i, debug_data_write_instruction_i, halted_i,
      exception_return_instruction_i, taken_branch_i, program_counter_sync_i, stopped_i,
      exception_i, emulator_entry_i, capture_ready_o, processor_status_code_oe_o,
      captured_data_nibble_oe_o, status_clock_out_o, status_clock_out_oe_o,
      debug_vs_scan_select_o;
   wire [3:0] oes = {1'b0, processor_status_code_oe_o, captured_data_nibble_oe_o,
      status_clock_out_oe_o};
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   assign {halted_i, stopped_i, emulator_entry_i, exception_i, program_counter_sync_i,
      taken_branch_i, exception_return_instruction_i, debug_data_write_instruction_i,
      user_entry_i, instr_begin_i} = ev;
   ptsp_status_port #(.HOLD_CYCLES(2)) uut (.*);
   ptsp_probe_model prb (.rst_i(rst_i), .status_clock_out_i(status_clock_out_o),
      .processor_status_code_i(processor_status_code_o),
      .captured_data_nibble_i(captured_data_nibble_o), .test_mode_o(test_mode_i));
   task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // inputs stand for exactly one tick edge; queue restarts after it
   task automatic launch(input logic [9:0] e, input logic v);
      do begin
         @(posedge sys_clk_i);
         #1;
      end while (status_clock_out_o !== 1'b1);
      @(posedge sys_clk_i);
      ev <= e;
      capture_valid_i <= v;
      #1 check("ready", {3'b0, capture_ready_o}, {3'b0, ~|e[9:6]});
      @(posedge sys_clk_i);
      ev <= 10'h000;
      capture_valid_i <= 1'b0;
      #1 prb.q.delete();
   endtask
   task automatic t_events;
      logic [9:0] evs [10] = '{10'h001, 10'h002, 10'h004, 10'h008, 10'h010, 10'h020,
         10'h040, 10'h080, 10'h050, 10'h005};
      logic [3:0] exp [10] = '{4'h1, 4'h3, 4'h4, 4'h7, 4'h5, 4'h5, 4'hC, 4'hD, 4'hC, 4'h4};
      for (int i = 0; i < 10; i++) begin
         launch(evs[i], 1'b0);
         repeat (8) @(posedge sys_clk_i);
         check("event code", prb.q[0][7:4], exp[i]);
         if (exp[i] > 4'hB) begin
            check("held code", prb.q[1][7:4], exp[i]);
            check("after hold", prb.q[2][7:4], 4'h0);
         end else
            check("next code", prb.q[1][7:4], 4'h0);
      end
      $display("t_events done");
   endtask
   task automatic t_capture;
      for (int b = 0; b < 4; b++) begin
         @(posedge sys_clk_i);
         capture_bytes_i <= 2'(b);
         capture_data_i <= 32'h5E7A_9BCD;
         launch(10'h000, 1'b1);
         repeat (24) @(posedge sys_clk_i);
         check("xfer code", prb.q[0][7:4], 4'h8 + 4'(b));
         for (int k = 0; k < 2 * b + 2; k++)
            check("nibble", prb.q[k + 1][3:0], capture_data_i[4 * k +: 4]);
         check("idle nibble", prb.q[2 * b + 3][3:0], breakpoint_status_i);
      end
      $display("t_capture done");
   endtask
   task automatic t_levels;
      @(posedge sys_clk_i);
      ev <= 10'h300;
      repeat (4) @(posedge sys_clk_i);
      #1 prb.q.delete();
      repeat (10) @(posedge sys_clk_i);
      for (int k = 0; k < 4; k++) check("halt", prb.q[k][7:4], 4'hF);
      ev <= 10'h100;
      repeat (16) @(posedge sys_clk_i);
      #1 prb.q.delete();
      repeat (10) @(posedge sys_clk_i);
      for (int k = 0; k < 4; k++) check("stop", prb.q[k][7:4], 4'hE);
      ev <= 10'h000;
      repeat (16) @(posedge sys_clk_i);
      #1 check("resume", processor_status_code_o, 4'h0);
      $display("t_levels done");
   endtask
   task automatic t_pins;
      @(posedge sys_clk_i);
      force_high_impedance_n_i <= 1'b0;
      #1 check("oe float", oes, 4'h0);
      @(posedge sys_clk_i);
      scan_active_i <= 1'b1;
      scan_output_enable_i <= 1'b1;
      #1 check("oe scan on", oes, 4'h7);
      @(posedge sys_clk_i);
      scan_output_enable_i <= 1'b0;
      force_high_impedance_n_i <= 1'b1;
      #1 check("oe scan off", oes, 4'h0);
      @(posedge sys_clk_i);
      scan_active_i <= 1'b0;
      #1 check("oe drive", oes, 4'h7);
      prb.set_mode(4'h1);
      repeat (3) @(posedge sys_clk_i);
      #1 check("debug select", {3'b0, debug_vs_scan_select_o}, 4'h1);
      prb.set_mode(4'h0);
      repeat (3) @(posedge sys_clk_i);
      #1 check("scan select", {3'b0, debug_vs_scan_select_o}, 4'h0);
      $display("t_pins done");
   endtask
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   // the whole run needs well under a thousand cycles
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      rst_i = 1'b1;
      ev = 10'h000;
      capture_valid_i = 1'b0;
      capture_data_i = 32'h0000_0000;
      capture_bytes_i = 2'h0;
      breakpoint_status_i = 4'h9;
      force_high_impedance_n_i = 1'b1;
      scan_active_i = 1'b0;
      scan_output_enable_i = 1'b0;
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      #1 check("reset code", processor_status_code_o, 4'h0);
      check("reset nibble", captured_data_nibble_o, 4'h0);
      check("clock in reset", {3'b0, status_clock_out_o}, 4'h0);
      @(posedge sys_clk_i);
      #1 check("clock first rise", {3'b0, status_clock_out_o}, 4'h1);
      t_events();
      t_capture();
      t_levels();
      t_pins();
      give_verdict();
   end
endmodule // ptsp_status_port_test
`default_nettype wire
